// ---- hw/field_memory_write_map.svh ----
/*
 Constants for the field memory write port.
 Assumes inclusion by the package, the design module or the properties module.
*/
`ifndef FIELD_MEMORY_WRITE_MAP_SVH
`define FIELD_MEMORY_WRITE_MAP_SVH
`define FMW_ADDR_W 19
`define FMW_PTR_LOWEST 19'h7fff4
`define FMW_PTR_ZERO 19'h00000
`define FMW_ARRAY_LAST 19'h3bfff
`define FMW_BLOCK_WORDS 19'h00028
`define FMW_BLOCK_W 13
`define FMW_BLOCK_MAX 13'h17ff
`define FMW_TEST_CYCLES 1024
`define FMW_EDGE_PAT2 5'h02
`define FMW_EDGE_PAT4 5'h04
`define FMW_EDGE_SEL 5'h05
`define FMW_EDGE_LSB 5'h11
`define FMW_FLUSH_CYCLES 5'h12
`define FMW_MIN_ADV 6'h28
`define FMW_WORD_W 12
`endif

// ---- hw/field_memory_write_pkg.sv ----
/*
 Types for the field memory write port.
 Assumes the map header is on the include path.
*/
`include "field_memory_write_map.svh"
package field_memory_write_pkg;
   typedef enum logic [2:0] {
      ENTRY_PATTERN,
      ENTRY_ADDRESS,
      ENTRY_FLUSH,
      ENTRY_IDLE,
      ENTRY_LOCKED
   } entry_state_t;
endpackage

// ---- hw/field_memory_write_port.sv ----
/*
 Write side of a 12-bit field memory: pointer, mini cache, write mask,
 random write block access and noise-reduction bit mapping.
 Assumes the serial write clock and all write controls arrive from pins
 and are sampled by ref_clk, which runs well above the write clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "field_memory_write_map.svh"

module field_memory_write_port
   import field_memory_write_pkg::*;
#(
   parameter int WORD_W = `FMW_WORD_W,
   parameter int TEST_CYCLES = `FMW_TEST_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic serial_write_clock,
   input wire logic write_pointer_reset,
   input wire logic write_advance_enable,
   input wire logic input_commit_enable,
   input wire logic noise_reduction_enable,
   input wire logic [WORD_W-1:0] data_in,
   output logic [WORD_W-1:0] reduction_data_out,
   output logic array_write,
   output logic [`FMW_ADDR_W-1:0] array_addr,
   output logic [WORD_W-1:0] array_data,
   output logic cache_write,
   output logic [3:0] cache_addr,
   output logic [WORD_W-1:0] cache_data,
   output logic flush_pulse,
   output logic [`FMW_ADDR_W-1:0] write_pointer,
   output logic block_access_active,
   output logic block_locked,
   output logic test_mode,
   output logic short_sequence
);

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   initial begin
      if (WORD_W != `FMW_WORD_W) $error("WORD_W must be 12");
      if (TEST_CYCLES < 2) $error("TEST_CYCLES too small");
      if (TEST_CYCLES > 2048) $error("TEST_CYCLES exceeds counter");
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   localparam int PINS = 5 + `FMW_WORD_W;
   logic [PINS-1:0] sync1_q, sync2_q;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (clk_en) begin
         sync1_q <= {serial_write_clock, write_pointer_reset,
                     write_advance_enable, input_commit_enable,
                     noise_reduction_enable, data_in};
         sync2_q <= sync1_q;
      end
   end
   logic serial_write_clock_s, rst_s, adv_s, com_s, nr_s;
   logic [WORD_W-1:0] din_s;
   assign {serial_write_clock_s, rst_s, adv_s, com_s, nr_s, din_s} = sync2_q;

   // ---------------------------------------------------------------
   // Write clock edge and reset edge detection
   // ---------------------------------------------------------------
   logic serial_write_clock_prev_q, rst_prev_q, reset_pend_q;
   wire edge_w = serial_write_clock_s & ~serial_write_clock_prev_q;
   wire rst_rise = rst_s & ~rst_prev_q;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         serial_write_clock_prev_q <= 1'b0;
         rst_prev_q <= 1'b0;
      end else if (clk_en) begin
         serial_write_clock_prev_q <= serial_write_clock_s;
         rst_prev_q <= rst_s;
      end
   end

   // Reset rise pends until next write clock edge, even if asynchronous
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         reset_pend_q <= 1'b0;
      end else if (clk_en) begin
         if (rst_rise && !edge_w) begin
            reset_pend_q <= 1'b1;
         end else if (edge_w) begin
            reset_pend_q <= 1'b0;
         end
      end
   end
   wire do_reset = edge_w & (reset_pend_q | rst_rise);

   // ---------------------------------------------------------------
   // Noise reduction bit mapping
   // ---------------------------------------------------------------
   logic [WORD_W-1:0] mapped;
   genvar gi;
   generate
      for (gi = 0; gi < WORD_W; gi++) begin : g_map
         // Luma and chroma already sit at mirrored pin positions
         assign mapped[gi] = din_s[gi];
      end
   endgenerate
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         reduction_data_out <= '0;
      end else if (clk_en && edge_w && nr_s) begin
         reduction_data_out <= mapped;
      end
   end

   // ---------------------------------------------------------------
   // Block access entry sequencer
   // ---------------------------------------------------------------
   entry_state_t state_q;
   logic [4:0] edge_cnt_q;
   logic on_commit_q;
   logic [`FMW_BLOCK_W-1:0] block_q;
   wire addr_bit = on_commit_q ? com_s : din_s[0];
   wire pat_ok = (edge_cnt_q < `FMW_EDGE_PAT2) ? (adv_s & ~com_s) :
                 (~adv_s & com_s);
   logic load_block;
   always_comb begin
      load_block = 1'b0;
      if (state_q == ENTRY_FLUSH && edge_w &&
          edge_cnt_q == `FMW_FLUSH_CYCLES - 5'h01) begin
         load_block = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_q <= ENTRY_IDLE;
         edge_cnt_q <= 5'h00;
         on_commit_q <= 1'b0;
         block_q <= '0;
      end else if (clk_en && do_reset) begin
         state_q <= nr_s ? ENTRY_IDLE : ENTRY_PATTERN;
         edge_cnt_q <= 5'h00;
         on_commit_q <= 1'b0;
         block_q <= '0;
      end else if (clk_en && edge_w) begin
         unique case (state_q)
            ENTRY_PATTERN: begin
               if (!pat_ok) begin
                  state_q <= ENTRY_IDLE;
               end else begin
                  edge_cnt_q <= edge_cnt_q + 5'h01;
                  if (edge_cnt_q == `FMW_EDGE_PAT4 - 5'h01) begin
                     state_q <= ENTRY_ADDRESS;
                  end
               end
            end
            ENTRY_ADDRESS: begin
               if (edge_cnt_q == `FMW_EDGE_SEL - 5'h01) begin
                  on_commit_q <= adv_s;
                  block_q <= {block_q[`FMW_BLOCK_W-2:0],
                              adv_s ? com_s : din_s[0]};
               end else begin
                  block_q <= {block_q[`FMW_BLOCK_W-2:0], addr_bit};
               end
               if (edge_cnt_q == `FMW_EDGE_LSB - 5'h01) begin
                  state_q <= ENTRY_FLUSH;
                  edge_cnt_q <= 5'h00;
               end else begin
                  edge_cnt_q <= edge_cnt_q + 5'h01;
               end
            end
            ENTRY_FLUSH: begin
               edge_cnt_q <= edge_cnt_q + 5'h01;
               if (load_block) begin
                  state_q <= (block_q > `FMW_BLOCK_MAX) ? ENTRY_LOCKED :
                             ENTRY_IDLE;
               end
            end
            ENTRY_IDLE: begin
            end
            ENTRY_LOCKED: begin
            end
         endcase
      end
   end
   assign block_access_active = (state_q == ENTRY_ADDRESS) ||
                                (state_q == ENTRY_FLUSH);
   assign block_locked = (state_q == ENTRY_LOCKED);
   wire flushing = (state_q == ENTRY_FLUSH);
   wire locked = block_locked;

   // ---------------------------------------------------------------
   // Write pointer
   // ---------------------------------------------------------------
   logic [`FMW_ADDR_W-1:0] ptr_q;
   wire [`FMW_ADDR_W-1:0] block_start =
      `FMW_ADDR_W'(block_q) * `FMW_BLOCK_WORDS;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ptr_q <= `FMW_PTR_LOWEST;
      end else if (clk_en && do_reset) begin
         ptr_q <= `FMW_PTR_LOWEST;
      end else if (clk_en && load_block) begin
         ptr_q <= block_start;
      end else if (clk_en && edge_w && adv_s && !flushing && !locked) begin
         if (ptr_q == `FMW_ARRAY_LAST) begin
            ptr_q <= `FMW_PTR_ZERO;
         end else begin
            ptr_q <= ptr_q + `FMW_ADDR_W'(1);
         end
      end
   end
   assign write_pointer = ptr_q;

   // ---------------------------------------------------------------
   // Data latch and commit (enables from previous edge)
   // ---------------------------------------------------------------
   logic adv_prev_q, com_prev_q;
   logic [`FMW_ADDR_W-1:0] ptr_prev_q;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         adv_prev_q <= 1'b0;
         com_prev_q <= 1'b0;
         ptr_prev_q <= `FMW_PTR_LOWEST;
      end else if (clk_en && edge_w) begin
         adv_prev_q <= adv_s;
         com_prev_q <= com_s;
         ptr_prev_q <= ptr_q;
      end
   end
   wire store = edge_w & adv_prev_q & com_prev_q & ~locked;
   wire in_cache = ptr_prev_q[`FMW_ADDR_W-1];
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         array_write <= 1'b0;
         array_addr <= '0;
         array_data <= '0;
      end else if (clk_en) begin
         // Noise reduction off: plain path, else mapped path
         array_write <= store & ~in_cache;
         if (store & ~in_cache) begin
            array_addr <= ptr_prev_q;
            array_data <= nr_s ? mapped : din_s;
         end
      end
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cache_write <= 1'b0;
         cache_addr <= 4'h0;
         cache_data <= '0;
      end else if (clk_en) begin
         cache_write <= store & in_cache;
         if (store & in_cache) begin
            cache_addr <= 4'(ptr_prev_q - `FMW_PTR_LOWEST);
            cache_data <= nr_s ? mapped : din_s;
         end
      end
   end

   // ---------------------------------------------------------------
   // Flush strobe, test mode and sequence length monitor
   // ---------------------------------------------------------------
   logic [10:0] test_cnt_q;
   logic [5:0] adv_cnt_q;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         flush_pulse <= 1'b0;
      end else if (clk_en) begin
         flush_pulse <= do_reset | load_block;
      end
   end

   // ---------------------------------------------------------------
   // Test mode entry
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         test_cnt_q <= 11'h000;
         test_mode <= 1'b0;
      end else if (clk_en && edge_w) begin
         if (rst_s && adv_s) begin
            if (32'(test_cnt_q) >= TEST_CYCLES - 1) begin
               test_mode <= 1'b1;
            end else begin
               test_cnt_q <= test_cnt_q + 11'h001;
            end
         end else begin
            test_cnt_q <= 11'h000;
         end
      end
   end

   // ---------------------------------------------------------------
   // Sequence length monitor
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         adv_cnt_q <= 6'h00;
         short_sequence <= 1'b0;
      end else if (clk_en && edge_w) begin
         if (do_reset) begin
            short_sequence <= (adv_cnt_q < `FMW_MIN_ADV);
            adv_cnt_q <= 6'h00;
         end else if (adv_s && adv_cnt_q < `FMW_MIN_ADV) begin
            adv_cnt_q <= adv_cnt_q + 6'h01;
         end
      end
   end

endmodule // field_memory_write_port
`default_nettype wire

// ---- bench/field_memory_write_properties.sv ----
/* Assertions on the field memory write port outputs.
 Assumes a bind from the testbench top file. */
`include "field_memory_write_map.svh"
`timescale 1ns/1ns
`default_nettype none
module field_memory_write_properties #(
   parameter int WORD_W = 12,
   parameter int TEST_CYCLES = 1024
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic noise_reduction_enable,
   input wire logic [WORD_W-1:0] reduction_data_out,
   input wire logic array_write,
   input wire logic [`FMW_ADDR_W-1:0] array_addr,
   input wire logic cache_write,
   input wire logic [3:0] cache_addr,
   input wire logic flush_pulse,
   input wire logic [`FMW_ADDR_W-1:0] write_pointer,
   input wire logic block_access_active,
   input wire logic block_locked,
   input wire logic test_mode
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence nr_held; noise_reduction_enable [*6]; endsequence
   sequence nr_off; !noise_reduction_enable [*6]; endsequence
   ptr_step_a: assert property ($changed(write_pointer) |->
      write_pointer == $past(write_pointer) + 19'h1 || flush_pulse
      || $past(flush_pulse)
      || (write_pointer == 19'h0 && $past(write_pointer) == 19'h3bfff))
      else $error("pointer moved other than by one");
   cache_range_a: assert property (cache_write |-> cache_addr <= 4'hb)
      else $error("cache index out of range");
   store_lock_a: assert property (block_locked |-> !array_write
      && !cache_write) else $error("store while locked");
   array_range_a: assert property (array_write |->
      array_addr <= 19'h3bfff) else $error("array address past end");
   test_sticky_a: assert property (test_mode |=> test_mode)
      else $error("test mode dropped");
   flush_once_a: assert property (flush_pulse |=> !flush_pulse)
      else $error("flush pulse longer than one cycle");
   block_start_a: assert property ($fell(block_access_active) |->
      ##[0:2] (write_pointer % 19'd40 == 19'h0
      || write_pointer == 19'h7fff4 || block_locked))
      else $error("block start not a multiple of forty");
   nr_block_a: assert property (nr_held |->
      !$rose(block_access_active)) else $error("block access with reduction");
   nr_bypass_a: assert property (nr_off |=>
      $stable(reduction_data_out)) else $error("reduction path moved");
endmodule // field_memory_write_properties
`default_nettype wire

// ---- bench/video_source_model.sv ----
/* Model of the video processor driving the write pins.
 Assumes the caller starts each task just after a ref_clk edge. */
`timescale 1ns/1ns
`default_nettype none
module video_source_model #(
   parameter int WORD_W = 12
) (
   output logic serial_write_clock,
   output logic write_pointer_reset,
   output logic write_advance_enable,
   output logic input_commit_enable,
   output logic [WORD_W-1:0] data_in
);
   initial begin
      serial_write_clock = 1'b0;
      write_pointer_reset = 1'b0;
      write_advance_enable = 1'b0;
      input_commit_enable = 1'b0;
      data_in = '0;
   end
   // One write clock period; clock idles low between calls
   task automatic wedge(input logic adv, input logic com,
         input logic [WORD_W-1:0] d);
      write_advance_enable = adv;
      input_commit_enable = com;
      data_in = d;
      #400 serial_write_clock = 1'b1;
      #400 serial_write_clock = 1'b0;
      data_in = ~d;
   endtask
   // Pointer reset edge, low again before the next edge
   task automatic start(input logic adv, input logic com);
      write_pointer_reset = 1'b0;
      wedge(1'b0, 1'b0, '0);
      write_pointer_reset = 1'b1;
      wedge(adv, com, '0);
      write_pointer_reset = 1'b0;
   endtask
   // Entry pattern, address shift and latency
   task automatic block(input logic [12:0] addr, input logic on_commit);
      start(1'b0, 1'b0);
      repeat (2) wedge(1'b1, 1'b0, '0);
      repeat (2) wedge(1'b0, 1'b1, '0);
      for (int i = 12; i >= 0; i--) begin
         if (on_commit) begin
            wedge(i == 12, addr[i], '0);
         end else begin
            wedge(1'b0, 1'b0, {{(WORD_W-1){1'b0}}, addr[i]});
         end
      end
      repeat (18) wedge(1'b0, 1'b0, '0);
   endtask
endmodule // video_source_model
`default_nettype wire

// ---- bench/testbench.sv ----
/* Self-checking bench for the field memory write port.
 Assumes the design package and map header are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic ref_clk, reset, clk_en, nr, swc, rst, adv, com;
   logic [11:0] din, rdo, adata, cdata;
   logic [18:0] aaddr, ptr;
   logic [3:0] caddr;
   logic aw, cw, flush, active, locked, tmode, short_seq;
   int fail_count = 0;
   int total_checks = 0;
   int n_wr = 0;
   video_source_model video_source_model_i (.serial_write_clock(swc),
      .write_pointer_reset(rst), .write_advance_enable(adv),
      .input_commit_enable(com), .data_in(din));
   field_memory_write_port #(.TEST_CYCLES(8)) field_memory_write_port_i (
      .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
      .serial_write_clock(swc), .write_pointer_reset(rst),
      .write_advance_enable(adv), .input_commit_enable(com),
      .noise_reduction_enable(nr), .data_in(din),
      .reduction_data_out(rdo), .array_write(aw), .array_addr(aaddr),
      .array_data(adata), .cache_write(cw), .cache_addr(caddr),
      .cache_data(cdata), .flush_pulse(flush), .write_pointer(ptr),
      .block_access_active(active), .block_locked(locked),
      .test_mode(tmode), .short_sequence(short_seq));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (aw === 1'b1 || cw === 1'b1) n_wr++;
   task automatic chk(input string n, input logic [18:0] e,
         input logic [18:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic settle();
      repeat (5) @(posedge ref_clk);
      #1;
   endtask
   task automatic results();
      if (fail_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic t_stream();
      video_source_model_i.start(1'b0, 1'b0);
      settle();
      chk("ptr reset", 19'h7fff4, ptr);
      n_wr = 0;
      repeat (50) video_source_model_i.wedge(1'b1, 1'b1, 12'h5a3);
      settle();
      chk("ptr adv", 19'h00026, ptr);
      chk("arr data", 19'h005a3, 19'(adata));
      chk("arr addr", 19'h00024, aaddr);
      chk("cache data", 19'h005a3, 19'(cdata));
      chk("cache addr", 19'h0000b, 19'(caddr));
      video_source_model_i.start(1'b0, 1'b0);
      settle();
      chk("flushed", 19'h1, 19'(n_wr >= 49));
      chk("long seq", 19'h0, 19'(short_seq));
      video_source_model_i.wedge(1'b1, 1'b1, 12'h0);
      n_wr = 0;
      repeat (45) video_source_model_i.wedge(1'b1, 1'b0, 12'hfff);
      video_source_model_i.start(1'b0, 1'b0);
      settle();
      chk("masked", 19'h1, 19'(n_wr <= 2));
      repeat (10) video_source_model_i.wedge(1'b1, 1'b1, 12'h0);
      video_source_model_i.start(1'b0, 1'b0);
      settle();
      chk("short seq", 19'h1, 19'(short_seq));
   endtask
   task automatic t_block();
      video_source_model_i.block(13'h0003, 1'b0);
      settle();
      chk("blk d0", 19'h00078, ptr);
      chk("blk done", 19'h0, 19'(active));
      video_source_model_i.block(13'h17ff, 1'b1);
      settle();
      chk("blk ie", 19'h3bfd8, ptr);
      repeat (40) video_source_model_i.wedge(1'b1, 1'b1, 12'h0);
      settle();
      chk("wrap", 19'h0, ptr);
      video_source_model_i.block(13'h1800, 1'b0);
      settle();
      chk("locked", 19'h1, 19'(locked));
      video_source_model_i.start(1'b0, 1'b0);
      settle();
      chk("unlocked", 19'h0, 19'(locked));
   endtask
   task automatic t_cancel();
      video_source_model_i.start(1'b0, 1'b0);
      repeat (2) video_source_model_i.wedge(1'b1, 1'b0, 12'h0);
      repeat (2) video_source_model_i.wedge(1'b0, 1'b1, 12'h0);
      video_source_model_i.wedge(1'b0, 1'b0, 12'h1);
      settle();
      chk("pattern ptr", 19'h7fff6, ptr);
      chk("entered", 19'h1, 19'(active));
      video_source_model_i.start(1'b0, 1'b0);
      settle();
      chk("cancel", 19'h0, 19'(active));
      chk("cancel ptr", 19'h7fff4, ptr);
   endtask
   task automatic t_nr();
      nr = 1'b1;
      settle();
      video_source_model_i.start(1'b0, 1'b0);
      repeat (2) video_source_model_i.wedge(1'b1, 1'b0, 12'h0);
      repeat (2) video_source_model_i.wedge(1'b0, 1'b1, 12'h0);
      video_source_model_i.wedge(1'b0, 1'b0, 12'h0);
      settle();
      chk("nr entry", 19'h0, 19'(active));
      video_source_model_i.wedge(1'b1, 1'b1, 12'h9c6);
      settle();
      chk("nr map", 19'h009c6, 19'(rdo));
      nr = 1'b0;
      settle();
   endtask
   task automatic t_test();
      video_source_model_i.write_pointer_reset = 1'b1;
      repeat (10) video_source_model_i.wedge(1'b1, 1'b1, 12'h0);
      video_source_model_i.write_pointer_reset = 1'b0;
      settle();
      chk("test mode", 19'h1, 19'(tmode));
   endtask
   initial begin
      reset = 1'b1;
      clk_en = 1'b1;
      nr = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 reset = 1'b0;
      settle();
      chk("ptr init", 19'h7fff4, ptr);
      t_stream();
      t_block();
      t_cancel();
      t_nr();
      t_test();
      results();
   end
   initial begin
      #1000000;
      fail_count++;
      results();
   end
endmodule // testbench
bind field_memory_write_port field_memory_write_properties #(
   .WORD_W(WORD_W), .TEST_CYCLES(TEST_CYCLES))
   field_memory_write_properties_i (.ref_clk(ref_clk), .reset(reset),
   .noise_reduction_enable(noise_reduction_enable),
   .reduction_data_out(reduction_data_out), .array_write(array_write),
   .array_addr(array_addr), .cache_write(cache_write),
   .cache_addr(cache_addr), .flush_pulse(flush_pulse),
   .write_pointer(write_pointer), .block_access_active(block_access_active),
   .block_locked(block_locked), .test_mode(test_mode));
`default_nettype wire
